// ### rtl/dac_special_command_decoder.v
// Operation
// - Both register-select bits zero: address bits pick a special command.
// - Code 1000 enters global power-down; data bits ignored.
// - Powered-down outputs are high impedance or 100k to ground.
// - Power-down select bit one gives high impedance, the reset default.
// - Register contents are kept unchanged through power-down.
// - Code 1001 powers up; exit completes within 8 us.
// - Effective power-down is hardware input OR software state.
// - Soft reset returns registers to defaults: gain full, offset zero.
// - Soft reset clears channel data to 0 V within 135 us.
// - Monitor code taken from data bits 13..8 on 14-bit parts.
// - Monitor code taken from data bits 11..6 on the 12-bit part.
// - Codes 0..15 route that channel; eight-channel part only 0..7.
// - Codes 100100 and 100101 route external inputs one and two.
// - Code 63 three-states the monitor pin.
// - Sources route only while the monitor enable bit is set.
// - Monitor enable cleared holds the pin high impedance; resets set.
// - Code 1100 loads the data word into the configuration word.
// - Configuration word is 14 bits, mapped straight from data bits.
`include "sfc_map.vh"
`timescale 1ns/100ps
`default_nettype none

module dac_special_command_decoder #(
    parameter DATA_WIDTH        = 14,
    parameter CHANNELS          = 16,
    parameter POWERUP_CYCLES    = `POWERUP_CYCLES,
    parameter SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input  wire                   clk,
    input  wire                   reset_n,
    // Decoded serial word, one-cycle strobe
    input  wire                   write_strobe,
    input  wire                   register_select_high,
    input  wire                   register_select_low,
    input  wire [3:0]             channel_address,
    input  wire [13:0]            data_word,
    input  wire                   hw_powerdown,
    output reg  [13:0]            output_config_word,
    output reg  [5:0]             monitor_select,
    output wire                   powerdown_active,
    output wire                   amp_high_impedance,
    output wire                   amp_ground_load,
    output reg                    powerup_settling,
    output reg                    soft_reset_busy,
    output reg                    register_defaults_load,
    output reg                    channel_data_clear,
    output wire [15:0]            monitor_channel_route,
    output wire                   monitor_ext_one_route,
    output wire                   monitor_ext_two_route
);

    localparam ST_IDLE   = 3'b001;
    localparam ST_PWRUP  = 3'b010;
    localparam ST_RESET  = 3'b100;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         soft_powerdown;
    reg  [31:0] timer;
    reg  [31:0] next_timer;
    wire        special_write;
    wire [5:0]  monitor_code;

    // Command is special only with both select bits low
    assign special_write = write_strobe & ~register_select_high &
                           ~register_select_low;

    // Monitor field position depends on converter width
    assign monitor_code = (DATA_WIDTH == 12) ? data_word[11:6]
                                             : data_word[13:8];

    // Power-down is either source; registers keep values meanwhile
    assign powerdown_active = hw_powerdown | soft_powerdown;
    assign amp_high_impedance = powerdown_active &
        output_config_word[`CFG_PD_SELECT_BIT];
    assign amp_ground_load = powerdown_active &
        ~output_config_word[`CFG_PD_SELECT_BIT];

    // Sequencer for the timed power-up and soft reset phases
    always @* begin
        next_state = state;
        next_timer = timer;
        case (state)
            ST_IDLE: begin
                if (special_write &&
                    channel_address == `SFC_CMD_POWERUP) begin
                    next_state = ST_PWRUP;
                    next_timer = POWERUP_CYCLES - 1;
                end else if (special_write &&
                             channel_address == `SFC_CMD_RESET) begin
                    next_state = ST_RESET;
                    next_timer = SOFT_RESET_CYCLES - 1;
                end
            end
            ST_PWRUP, ST_RESET: begin
                if (timer == 32'h0000_0000) begin
                    next_state = ST_IDLE;
                end else begin
                    next_timer = timer - 32'h0000_0001;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_timer = 32'h0000_0000;
            end
        endcase
    end

    // State, timer and status flags
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state            <= ST_IDLE;
            timer            <= 32'h0000_0000;
            powerup_settling <= 1'b0;
            soft_reset_busy  <= 1'b0;
        end else begin
            state            <= next_state;
            timer            <= next_timer;
            powerup_settling <= (next_state == ST_PWRUP);
            soft_reset_busy  <= (next_state == ST_RESET);
        end
    end

    // Command execution; commands during a busy phase are still taken
    // so a host can power down again mid settle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_config_word     <= `CFG_RESET_VALUE;
            monitor_select         <= `MON_SEL_RESET;
            soft_powerdown         <= 1'b0;
            register_defaults_load <= 1'b0;
            channel_data_clear     <= 1'b0;
        end else begin
            register_defaults_load <= 1'b0;
            channel_data_clear     <= 1'b0;
            if (special_write) begin
                case (channel_address)
                    `SFC_CMD_POWERDOWN: begin
                        soft_powerdown <= 1'b1;
                    end
                    `SFC_CMD_POWERUP: begin
                        soft_powerdown <= 1'b0;
                    end
                    `SFC_CMD_MONITOR: begin
                        monitor_select <= monitor_code;
                    end
                    `SFC_CMD_CONFIG: begin
                        output_config_word <= data_word;
                    end
                    `SFC_CMD_RESET: begin
                        // Host keeps this out of power-down
                        output_config_word     <= `CFG_RESET_VALUE;
                        monitor_select         <= `MON_SEL_RESET;
                        register_defaults_load <= 1'b1;
                        channel_data_clear     <= 1'b1;
                    end
                    default: begin
                        soft_powerdown <= soft_powerdown;
                    end
                endcase
            end
        end
    end

    // Analog monitor switch decode
    monitor_route #(
        .CHANNELS (CHANNELS)
    ) u_monitor_route (
        .selection      (monitor_select),
        .monitor_enable (output_config_word[`CFG_MON_ENABLE_BIT]),
        .channel_route  (monitor_channel_route),
        .ext_one_route  (monitor_ext_one_route),
        .ext_two_route  (monitor_ext_two_route)
    );

endmodule // dac_special_command_decoder

`default_nettype wire

// ### rtl/sfc_map.vh
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// Command codes on the channel address field
`define SFC_CMD_NOP         4'h0
`define SFC_CMD_POWERDOWN   4'h8
`define SFC_CMD_POWERUP     4'h9
`define SFC_CMD_MONITOR     4'ha
`define SFC_CMD_CONFIG      4'hc
`define SFC_CMD_RESET       4'hf

// Configuration word layout and power-on value
`define CFG_WIDTH           14
`define CFG_PD_SELECT_BIT   13
`define CFG_MON_ENABLE_BIT  9
`define CFG_RESET_VALUE     14'h2200

// Monitor selection codes
`define MON_EXT_ONE         6'h24
`define MON_EXT_TWO         6'h25
`define MON_TRISTATE        6'h3f
`define MON_SEL_RESET       6'h3f

// Timing: figures in ns, clock period in ns
`define CLK_PERIOD_NS       10
`define POWERUP_TIME_NS     8000
`define SOFT_RESET_TIME_NS  135000
// Longest times round down
`define POWERUP_CYCLES      (`POWERUP_TIME_NS / `CLK_PERIOD_NS)
`define SOFT_RESET_CYCLES   (`SOFT_RESET_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/monitor_route.v
`include "sfc_map.vh"
`timescale 1ns/100ps
`default_nettype none

// Decodes the monitor selection into a one-hot source choice
module monitor_route #(
    parameter CHANNELS = 16
) (
    input  wire [5:0]  selection,
    input  wire        monitor_enable,
    output reg  [15:0] channel_route,
    output reg         ext_one_route,
    output reg         ext_two_route
);

    // Undefined codes leave every switch open, so the pin floats
    always @* begin
        channel_route = 16'h0000;
        ext_one_route = 1'b0;
        ext_two_route = 1'b0;
        if (monitor_enable) begin
            if (selection < CHANNELS) begin
                channel_route[selection[3:0]] = 1'b1;
            end else if (selection == `MON_EXT_ONE) begin
                ext_one_route = 1'b1;
            end else if (selection == `MON_EXT_TWO) begin
                ext_two_route = 1'b1;
            end
            // All ones and undefined codes: nothing routed
        end
    end

endmodule // monitor_route

`default_nettype wire

// ### bench/sfc_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on the decoder; all checks share one clock
module sfc_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        write_strobe,
    input wire logic        register_select_high,
    input wire logic        register_select_low,
    input wire logic [3:0]  channel_address,
    input wire logic [13:0] data_word,
    input wire logic        hw_powerdown,
    input wire logic [13:0] output_config_word,
    input wire logic [5:0]  monitor_select,
    input wire logic        powerdown_active,
    input wire logic        amp_high_impedance,
    input wire logic        amp_ground_load,
    input wire logic        powerup_settling,
    input wire logic        soft_reset_busy,
    input wire logic        register_defaults_load,
    input wire logic        channel_data_clear,
    input wire logic [15:0] monitor_channel_route,
    input wire logic        monitor_ext_one_route,
    input wire logic        monitor_ext_two_route
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Accepted special command with a given code
    sequence cmd(logic [3:0] c);
        write_strobe && !register_select_high && !register_select_low
            && channel_address == c;
    endsequence
    // Soft reset: both pulses with the config word at defaults
    sequence clr_pulse;
        channel_data_clear && register_defaults_load
            && output_config_word == 14'h2200;
    endsequence
    a_pd_enter: assert property (cmd(4'h8) |=> powerdown_active)
        else $error("power-down not entered");
    a_pd_or: assert property (hw_powerdown |-> powerdown_active)
        else $error("hardware power-down ignored");
    a_amp_mode: assert property (powerdown_active |->
        amp_high_impedance == output_config_word[13]
        && amp_ground_load == !output_config_word[13])
        else $error("amplifier mode wrong");
    a_cfg_load: assert property (cmd(4'hc)
        |=> output_config_word == $past(data_word))
        else $error("config word not loaded");
    a_mon_load: assert property (cmd(4'ha)
        |=> {8'h00, monitor_select} == ($past(data_word) >> 8))
        else $error("monitor code not loaded");
    a_mon_off: assert property (!output_config_word[9]
        |-> monitor_channel_route == 16'h0000 && !monitor_ext_one_route
        && !monitor_ext_two_route)
        else $error("route while monitor disabled");
    a_mon_chan: assert property (output_config_word[9]
        && monitor_select < 6'h10
        |-> monitor_channel_route == (16'h0001 << monitor_select))
        else $error("channel route wrong");
    a_mon_ext: assert property (output_config_word[9]
        && monitor_select == 6'h24 |-> monitor_ext_one_route)
        else $error("external input not routed");
    a_mon_tri: assert property (monitor_select == 6'h3f
        |-> monitor_channel_route == 16'h0000 && !monitor_ext_one_route
        && !monitor_ext_two_route)
        else $error("tristate code routes");
    a_pd_keep: assert property (powerdown_active && !write_strobe
        |=> $stable(output_config_word))
        else $error("config lost in power-down");
    a_pu_exit: assert property (cmd(4'h9) && !hw_powerdown
        && !powerup_settling && !soft_reset_busy
        |=> powerup_settling && !powerdown_active)
        else $error("power-up not started");
    a_soft_rst: assert property (cmd(4'hf) && !soft_reset_busy
        |=> clr_pulse ##1 !channel_data_clear)
        else $error("soft reset sequence wrong");
endmodule // sfc_checker
bind dac_special_command_decoder sfc_checker i_chk (.*);
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side; released address and data scrambled so stale data never helps
module host_model (
    input  wire logic        clk,
    output var  logic        write_strobe,
    output var  logic        register_select_high,
    output var  logic        register_select_low,
    output var  logic [3:0]  channel_address,
    output var  logic [13:0] data_word
);
    // Idle at time zero
    initial begin
        write_strobe = 1'b0;
        register_select_high = 1'b1;
        register_select_low = 1'b1;
        channel_address = 4'h0;
        data_word = 14'h0000;
    end
    // One whole word for one edge
    task issue(input logic s, input logic [3:0] c, input logic [13:0] d);
        @(posedge clk);
        write_strobe <= 1'b1;
        register_select_high <= s;
        register_select_low <= s;
        channel_address <= c;
        data_word <= d;
        @(posedge clk);
        write_strobe <= 1'b0;
        channel_address <= ~c;
        data_word <= ~d;
    endtask
endmodule // host_model
`default_nettype wire

// ### bench/dac_special_command_decoder_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dac_special_command_decoder_bench;
    logic        clk, reset_n, hw_powerdown;
    wire         write_strobe, register_select_high, register_select_low;
    wire  [3:0]  channel_address;
    wire  [13:0] data_word, output_config_word;
    wire  [5:0]  monitor_select;
    wire  [15:0] monitor_channel_route;
    wire         powerdown_active, amp_high_impedance, amp_ground_load;
    wire         powerup_settling, soft_reset_busy, register_defaults_load;
    wire         channel_data_clear, monitor_ext_one_route;
    wire         monitor_ext_two_route;
    integer      error_cnt = 0, checks = 0, cyc = 0;
    // Short timed phases keep the run brief
    dac_special_command_decoder #(.POWERUP_CYCLES(4),
        .SOFT_RESET_CYCLES(6)) i_dut (.*);
    host_model i_host (.*);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks = checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task cmd(input logic [3:0] c, input logic [13:0] d);
        i_host.issue(1'b0, c, d);
        #1;
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wrap_up;
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the test length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            wrap_up;
        end
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        hw_powerdown = 1'b0;
        tick(20);
        reset_n <= 1'b1;
        tick(1);
        chk("cfg", 16'h2200, output_config_word);
        chk("msel", 16'h003f, monitor_select);
        cmd(4'hc, 14'h0200);
        cmd(4'ha, 14'h0500);
        chk("route", 16'h0020, monitor_channel_route);
        cmd(4'ha, 14'h2400);
        chk("ext1", 16'h1, monitor_ext_one_route);
        cmd(4'ha, 14'h2500);
        chk("ext2", 16'h1, monitor_ext_two_route);
        cmd(4'ha, 14'h3000);
        chk("undef", 16'h0, monitor_channel_route | {monitor_ext_one_route,
            monitor_ext_two_route});
        cmd(4'ha, 14'h3f00);
        chk("tri", 16'h0, monitor_channel_route);
        cmd(4'ha, 14'h0500);
        cmd(4'hc, 14'h0000);
        chk("off", 16'h0, monitor_channel_route);
        i_host.issue(1'b1, 4'hc, 14'h1234);
        tick(1);
        chk("sel", 16'h0, output_config_word);
        cmd(4'h8, 14'h3fff);
        chk("pd", 16'h1, powerdown_active);
        chk("gnd", 16'h1, amp_ground_load);
        chk("keep", 16'h0, output_config_word);
        cmd(4'hc, 14'h2000);
        chk("hiz", 16'h1, amp_high_impedance);
        cmd(4'h9, 14'h3fff);
        chk("pu", 16'h1, powerup_settling & !powerdown_active);
        tick(3);
        chk("settle", 16'h1, powerup_settling);
        tick(1);
        chk("settled", 16'h0, powerup_settling);
        hw_powerdown <= 1'b1;
        tick(1);
        chk("hw", 16'h1, powerdown_active);
        hw_powerdown <= 1'b0;
        cmd(4'hc, 14'h0123);
        cmd(4'hf, 14'h0000);
        chk("clr", 16'h1, channel_data_clear & register_defaults_load);
        chk("dflt", 16'h2200, output_config_word);
        tick(5);
        chk("busy", 16'h1, soft_reset_busy);
        tick(1);
        chk("done", 16'h0, soft_reset_busy);
        wrap_up;
    end
endmodule // dac_special_command_decoder_bench
`default_nettype wire
